// >>> core/sac_device.sv
// Converter end: successive-approximation sequencer
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_device (
   input  wire logic        clock,
   input  wire logic        rst_n,
   sac_if.dev               link,
   input  wire logic        ext_clk_mode,
   input  sac_pkg::sac_res_t res_sel,
   input  wire logic        cmp_high,
   output logic             conv_done
);
   import sac_pkg::*;

   ////////////////////////////////////////////////////////////
   // State

   sac_dev_state_t     state;
   logic               start_s;
   logic               start_d;
   logic [3:0]         idx;
   logic [7:0]         cnt;
   logic [`SAC_MSB:0]  code;
   logic [`SAC_MSB:0]  next_code;
   logic               busy;
   logic               bclk;
   logic               sdata;
   logic               msb_n;

   ////////////////////////////////////////////////////////////
   // Start input crossing

   // Start comes from the far party, so it is synchronised
   sac_sync #(
      .W (1)
   ) u_start_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     (link.start),
      .q     (start_s)
   );

   // Previous synced level for edge finding
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         start_d <= 1'b0;
      end else begin
         start_d <= start_s;
      end
   end

   // Edges of the synced start level
   wire start_fall = start_d & ~start_s;
   wire start_rise = ~start_d & start_s;

   ////////////////////////////////////////////////////////////
   // Resolution selection

   // RULE_05 truncate picks end bit
   wire last_idx_8  = (res_sel == SAC_RES_8);
   wire last_idx_10 = (res_sel == SAC_RES_10);
   wire [3:0] lsb_idx = last_idx_8  ? `SAC_LSB_IDX_8 :
                        last_idx_10 ? `SAC_LSB_IDX_10 :
                                      `SAC_LSB_IDX_12;

   // RULE_06 slot length per resolution
   // Only 8-bit words use a faster slot to meet the shorter limit; 10-bit keeps the 12-bit slot
   wire [7:0] slot_cyc = last_idx_8  ? 8'(`SAC_BIT_CYC_8) :
                         last_idx_10 ? 8'(`SAC_BIT_CYC_10) :
                                       8'(`SAC_BIT_CYC_12);

   // RULE_14 internal bit clock slot
   wire [7:0] slot_half = slot_cyc >> 1;
   wire [7:0] slot_last = slot_cyc - 8'h1;

   ////////////////////////////////////////////////////////////
   // Sequencing events

   wire idle = (state == SAC_IDLE);
   wire conv = (state == SAC_CONV);

   // RULE_01 trailing edge launches
   wire launch = idle & start_fall;

   // RULE_07 external pulses pace the steps
   wire ext_step = conv & ext_clk_mode & start_fall;
   wire int_mid  = conv & ~ext_clk_mode & (cnt == slot_half);
   wire int_end  = conv & ~ext_clk_mode & (cnt == slot_last);

   // RULE_09 first fall launches, twelve falls decide
   // Fall 13 decides the LSB; the next fall relaunches
   wire decide   = ext_step | int_mid;
   wire step_end = ext_step | int_end;

   wire last_bit = (idx == lsb_idx);
   wire finish   = step_end & last_bit;

   // RULE_10 complementary bit: zero when input above trial
   wire kept_c = ~cmp_high;

   ////////////////////////////////////////////////////////////
   // Approximation register

   // RULE_16 one bit per slot, MSB first
   always_comb begin
      next_code = code;
      if (launch) begin
         // RULE_12 full 12-bit word, loaded with the MSB trial code
         next_code = `SAC_TRIAL_INIT;
      end else begin
         if (decide) begin
            next_code[idx] = kept_c;
         end
         if (step_end && !last_bit) begin
            next_code[idx - 4'h1] = 1'b0;
         end
      end
   end

   // RULE_17 register only moves while converting
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         code  <= `SAC_ALL_ONES;
         msb_n <= 1'b0;
      end else begin
         code  <= next_code;
         // RULE_11 inverted MSB copy
         msb_n <= ~next_code[`SAC_MSB];
      end
   end

   ////////////////////////////////////////////////////////////
   // Control flow

   // Sequencer state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= SAC_IDLE;
      end else if (launch) begin
         state <= SAC_CONV;
      end else if (finish) begin
         state <= SAC_IDLE;
      end
   end

   // RULE_13 busy spans the conversion
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else if (launch) begin
         busy <= 1'b1;
      end else if (finish) begin
         busy <= 1'b0;
      end
   end

   // Bit index walks down from the MSB
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idx <= 4'h0;
      end else if (launch) begin
         idx <= 4'(`SAC_MSB);
      end else if (step_end && !last_bit) begin
         idx <= idx - 4'h1;
      end
   end

   // Slot counter, idle in external mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h0;
      end else if (launch || int_end) begin
         cnt <= 8'h0;
      end else if (conv && !ext_clk_mode) begin
         cnt <= cnt + 8'h1;
      end
   end

   ////////////////////////////////////////////////////////////
   // Serial stream and bit clock

   // RULE_15 NRZ bit as decided, same code as parallel
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sdata <= 1'b0;
      end else if (decide) begin
         sdata <= kept_c;
      end
   end

   // RULE_04 data set half a slot (internal) or one start low width (external) before clock falls
   // Rise with the new bit; fall gives the receiver's strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bclk <= 1'b0;
      end else if (decide) begin
         bclk <= 1'b1;
      end else if (int_end || start_rise) begin
         bclk <= 1'b0;
      end
   end

   // One-cycle completion pulse for the user side
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         conv_done <= 1'b0;
      end else begin
         conv_done <= finish;
      end
   end

   ////////////////////////////////////////////////////////////
   // Link outputs, all from flops

   assign link.busy         = busy;
   assign link.bit_clk      = bclk;
   assign link.serial_data  = sdata;
   assign link.result       = code;
   assign link.result_msb_n = msb_n;

endmodule

// >>> core/sac_host.sv
// Host end: starts conversions and collects results
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_host (
   input  wire logic        clock,
   input  wire logic        rst_n,
   sac_if.host              link,
   input  wire logic [2:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   output logic             irq
);
   import sac_pkg::*;

   sac_host_state_t    hs;
   sac_host_state_t    next_hs;
   logic [7:0]         cnt;
   logic [7:0]         next_cnt;
   logic [3:0]         pulses;
   logic [3:0]         next_pulses;
   logic               start;
   logic               next_start;
   logic               seen_busy;
   logic               ctrl_ext;
   logic [1:0]         stat;
   logic [1:0]         en;
   logic [12:0]        res_q;
   logic [11:0]        ser_q;
   logic [15:0]        link_s;
   logic               busy_d;
   logic               bclk_d;

   ////////////////////////////////////////////////////////////
   // Link inputs crossing

   sac_sync #(
      .W (16)
   ) u_link_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({link.busy, link.bit_clk, link.serial_data,
               link.result_msb_n, link.result}),
      .q     (link_s)
   );

   wire        busy_s = link_s[15];
   wire        bclk_s = link_s[14];
   wire        sd_s   = link_s[13];
   wire [12:0] res_s  = link_s[12:0];
   wire        busy_fall = busy_d & ~busy_s;
   wire        bclk_fall = bclk_d & ~bclk_s;

   ////////////////////////////////////////////////////////////
   // Register decode

   wire wr_ctrl = wr & (addr == `SAC_A_CTRL);
   wire wr_clr  = wr & (addr == `SAC_A_CLR);
   wire wr_en   = wr & (addr == `SAC_A_EN);
   wire go      = wr_ctrl & wdata[`SAC_CTRL_GO] & (hs == SAC_H_IDLE);
   // Mode comes with the GO write itself, not the old register value
   wire go_ext  = go & wdata[`SAC_CTRL_EXT];

   // Events; a set in the clear cycle survives
   wire [1:0] ev;
   assign ev[`SAC_EV_DONE] = busy_fall;
   assign ev[`SAC_EV_OVR]  = busy_fall & stat[`SAC_EV_DONE];
   wire [1:0] clr_mask  = wr_clr ? wdata[1:0] : 2'h0;
   wire [1:0] next_stat = (stat & ~clr_mask) | ev;
   wire [1:0] next_en   = wr_en ? wdata[1:0] : en;

   // Read selection
   wire [15:0] rmux =
      (addr == `SAC_A_CTRL) ? {14'h0, ctrl_ext, 1'b0} :
      (addr == `SAC_A_STAT) ? {13'h0, busy_s, stat} :
      (addr == `SAC_A_EN)   ? {14'h0, en} :
      (addr == `SAC_A_RES)  ? {3'h0, res_q} :
      (addr == `SAC_A_SER)  ? {4'h0, ser_q} : 16'h0;

   ////////////////////////////////////////////////////////////
   // Start generator

   always_comb begin
      next_hs     = hs;
      next_cnt    = (cnt == 8'h0) ? 8'h0 : cnt - 8'h1;
      next_pulses = pulses;
      next_start  = start;
      unique case (hs)
         SAC_H_IDLE: begin
            // Start rests high so no stray fall appears
            next_start = 1'b1;
            if (go_ext) begin
               // RULE_02 rest high before first pacing fall
               next_hs     = SAC_H_PHI;
               next_cnt    = 8'(`SAC_START_HI_CYC - 1);
               next_pulses = 4'h0;
            end else if (go) begin
               // RULE_02 high at least 50 ns first
               next_hs  = SAC_H_HIGH;
               next_cnt = 8'(`SAC_START_HI_CYC - 1);
            end
         end
         SAC_H_HIGH: begin
            if (cnt == 8'h0) begin
               next_hs    = SAC_H_WAIT;
               next_start = 1'b0;
            end
         end
         SAC_H_WAIT: begin
            // RULE_03 start low until busy clears
            if (seen_busy && !busy_s) begin
               next_hs    = SAC_H_IDLE;
               next_start = 1'b1;
            end
         end
         SAC_H_PLO: begin
            // RULE_08 low width 150 ns
            if (cnt == 8'h0) begin
               next_hs     = SAC_H_PHI;
               next_start  = 1'b1;
               next_cnt    = 8'(`SAC_EXT_HI_CYC - 1);
               next_pulses = pulses + 4'h1;
            end
         end
         SAC_H_PHI: begin
            // RULE_09 thirteen pulses per conversion
            if (cnt == 8'h0 && pulses == `SAC_EXT_PULSES) begin
               next_hs = SAC_H_IDLE;
            end else if (cnt == 8'h0) begin
               // RULE_07 pulses on start pace it
               next_hs    = SAC_H_PLO;
               next_start = 1'b0;
               next_cnt   = 8'(`SAC_EXT_LO_CYC - 1);
            end
         end
      endcase
   end

   // Generator flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hs     <= SAC_H_IDLE;
         cnt    <= 8'h0;
         pulses <= 4'h0;
         start  <= 1'b0;
      end else begin
         hs     <= next_hs;
         cnt    <= next_cnt;
         pulses <= next_pulses;
         start  <= next_start;
      end
   end

   // Busy must be seen high before its fall counts
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_busy <= 1'b0;
      end else if (go) begin
         seen_busy <= 1'b0;
      end else if (busy_s) begin
         seen_busy <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////
   // Result capture

   // RULE_04 shift serial bit at clock fall
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ser_q <= 12'h0;
      end else if (go) begin
         ser_q <= 12'h0;
      end else if (bclk_fall) begin
         ser_q <= {ser_q[10:0], sd_s};
      end
   end

   // Parallel word is stable once busy is low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_d <= 1'b0;
         bclk_d <= 1'b0;
         res_q  <= 13'h0;
      end else begin
         busy_d <= busy_s;
         bclk_d <= bclk_s;
         if (busy_fall) begin
            res_q <= res_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Registers, interrupt and read port

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ext <= 1'b0;
         stat     <= 2'h0;
         en       <= 2'h0;
         irq      <= 1'b0;
         rdata    <= 16'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ext <= wdata[`SAC_CTRL_EXT];
         end
         stat  <= next_stat;
         en    <= next_en;
         irq   <= |(next_stat & next_en);
         rdata <= rd ? rmux : 16'h0;
      end
   end

   assign link.start = start;

endmodule

// >>> core/sac_if.sv
// Link between converter sequencer and host controller
`timescale 1ns/1ps
`include "sac_params.svh"
interface sac_if;
   logic                start;
   logic                busy;
   logic                bit_clk;
   logic                serial_data;
   logic [`SAC_MSB:0]   result;
   logic                result_msb_n;

   modport dev (
      input  start,
      output busy,
      output bit_clk,
      output serial_data,
      output result,
      output result_msb_n
   );
   modport host (
      output start,
      input  busy,
      input  bit_clk,
      input  serial_data,
      input  result,
      input  result_msb_n
   );
endinterface

// >>> core/sac_params.svh
// Constants of the conversion sequencer and its controller
// Contract
// RULE_01 - Conversion starts on start falling edge
// RULE_02 - Host holds start high 50 ns first
// RULE_03 - Host keeps start low until not busy
// RULE_04 - Receiver samples serial data on clock fall
// RULE_05 - Truncate input ends conversion early
// RULE_06 - Max times 10, 8, 4 us
// RULE_07 - External pulses on start pace conversion
// RULE_08 - External pulse low 100 to 200 ns
// RULE_09 - Thirteen pulses; fourteenth fall restarts
// RULE_10 - Complementary straight or offset binary codes
// RULE_11 - Inverted MSB copy gives two's complement
// RULE_12 - Full resolution word is 12 bits
// RULE_13 - Busy high for whole conversion
// RULE_14 - Bit clock nominal 1.4 MHz internally; 8-bit runs a 49-cycle slot instead (about 2 MHz)
// RULE_15 - Serial output NRZ, same coding
// RULE_16 - One bit per clock, MSB first
// RULE_17 - Parallel result holds while not busy
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Clock and word
`define SAC_CLK_KHZ      100000
`define SAC_W            12
`define SAC_MSB          11
`define SAC_TRIAL_INIT   12'h7ff
`define SAC_ALL_ONES     12'hfff

// Internal bit clock and conversion time limits
`define SAC_BCLK_KHZ     1400
`define SAC_TMAX12_US    10
`define SAC_TMAX10_US    8
`define SAC_TMAX8_US     4
`define SAC_SYNC_SLACK   4
`define SAC_BCLK_CYC     (`SAC_CLK_KHZ / `SAC_BCLK_KHZ)
`define SAC_FIT(t, n)    ((((t) * `SAC_CLK_KHZ / 1000) - `SAC_SYNC_SLACK) / (n))
`define SAC_MIN(a, b)    (((a) < (b)) ? (a) : (b))
`define SAC_BIT_CYC_12   `SAC_MIN(`SAC_BCLK_CYC, `SAC_FIT(`SAC_TMAX12_US, 12))
`define SAC_BIT_CYC_10   `SAC_MIN(`SAC_BCLK_CYC, `SAC_FIT(`SAC_TMAX10_US, 10))
`define SAC_BIT_CYC_8    `SAC_MIN(`SAC_BCLK_CYC, `SAC_FIT(`SAC_TMAX8_US, 8))
`define SAC_LSB_IDX_12   4'h0
`define SAC_LSB_IDX_10   4'h2
`define SAC_LSB_IDX_8    4'h4

// Host start pulse timing (least times round up)
`define SAC_NS_CEIL(ns)  ((((ns) * `SAC_CLK_KHZ / 1000) + 999) / 1000)
`define SAC_START_HI_NS  50
`define SAC_EXT_LO_NS    150
`define SAC_EXT_HI_NS    250
`define SAC_START_HI_CYC `SAC_NS_CEIL(`SAC_START_HI_NS)
`define SAC_EXT_LO_CYC   `SAC_NS_CEIL(`SAC_EXT_LO_NS)
`define SAC_EXT_HI_CYC   `SAC_NS_CEIL(`SAC_EXT_HI_NS)
`define SAC_EXT_PULSES   4'hd

// Host register map
`define SAC_A_CTRL       3'h0
`define SAC_A_STAT       3'h1
`define SAC_A_CLR        3'h2
`define SAC_A_EN         3'h3
`define SAC_A_RES        3'h4
`define SAC_A_SER        3'h5
`define SAC_CTRL_GO      0
`define SAC_CTRL_EXT     1
`define SAC_EV_DONE      0
`define SAC_EV_OVR       1
`define SAC_STAT_BUSY    2

`endif

// >>> core/sac_pkg.sv
// Types shared by both ends of the conversion sequencer
package sac_pkg;
   typedef enum logic [1:0] {SAC_RES_12, SAC_RES_10, SAC_RES_8} sac_res_t;
   typedef enum logic {SAC_IDLE, SAC_CONV} sac_dev_state_t;
   typedef enum logic [2:0] {
      SAC_H_IDLE,
      SAC_H_HIGH,
      SAC_H_WAIT,
      SAC_H_PLO,
      SAC_H_PHI
   } sac_host_state_t;
endpackage

// >>> core/sac_sync.sv
// Two-flop synchroniser for levels from another domain
`timescale 1ns/1ps
module sac_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// >>> sim/sac_link_checker.sv
// Concurrent checks on the link between converter and host ends
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_link_checker (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              start,
   input wire logic              busy,
   input wire logic              bit_clk,
   input wire logic              serial_data,
   input wire logic [`SAC_MSB:0] result,
   input wire logic              result_msb_n
);
   localparam int MAX_DWELL = 1000;
   logic        busy_q;
   logic        clk_q;
   logic [4:0]  bits;
   logic [10:0] dwell;
   logic [4:0]  next_bits;
   logic [10:0] next_dwell;
   logic [7:0]  hi_run;
   logic [7:0]  next_hi_run;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////
   // Per-conversion tallies; dwell saturates so a hung busy cannot wrap
   assign next_bits  = (busy && !busy_q) ? 5'h0 : bits + {4'h0, bit_clk && !clk_q};
   assign next_dwell = !busy ? 11'h0 : (dwell == 11'h7ff) ? dwell : dwell + 11'h1;
   assign next_hi_run = !start ? 8'h0 : (hi_run == 8'hff) ? hi_run : hi_run + 8'h1;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         clk_q  <= 1'b0;
         bits   <= 5'h0;
         dwell  <= 11'h0;
         hi_run <= 8'h0;
      end else begin
         busy_q <= busy;
         clk_q  <= bit_clk;
         bits   <= next_bits;
         dwell  <= next_dwell;
         hi_run <= next_hi_run;
      end
   end

   ////////////////////////////////////////////////////////////////
   chk_msb_copy: assert property (result_msb_n == !result[`SAC_MSB])
      else $error("inverted msb differs");
   chk_launch_low: assert property ($rose(busy) |-> !start && result == `SAC_TRIAL_INIT)
      else $error("launch without low start or msb trial");
   chk_fall_launch: assert property ($fell(start) && !busy |-> ##[1:6] busy)
      else $error("start fall did not launch");
   chk_hold_idle: assert property (!busy && !$past(busy) |-> $stable(result))
      else $error("result moved while idle");
   chk_clk_in_conv: assert property ($rose(bit_clk) |-> $past(busy))
      else $error("bit clock outside conversion");
   chk_strobe_data: assert property ($fell(bit_clk) |-> $stable(serial_data))
      else $error("serial data moved at strobe");
   chk_nrz_hold: assert property (bit_clk && $past(bit_clk) |-> $stable(serial_data))
      else $error("serial data moved in bit");
   chk_bit_total: assert property ($fell(busy) |=> bits == 5'd12 || bits == 5'd10 || bits == 5'd8)
      else $error("wrong bit count");
   chk_bit_limit: assert property (bits <= 5'd12)
      else $error("more than twelve bits");
   chk_conv_time: assert property (dwell <= MAX_DWELL)
      else $error("conversion too long");
   chk_start_high: assert property ($fell(start) |-> hi_run >= 8'(`SAC_START_HI_CYC))
      else $error("start high too short before fall");

   // Main scenarios: each resolution completes
   cov_full: cover property ($fell(busy) ##1 bits == 5'd12);
   cov_ten: cover property ($fell(busy) ##1 bits == 5'd10);
   cov_eight: cover property ($fell(busy) ##1 bits == 5'd8);
endmodule

// >>> sim/testbench.sv
// Self-checking bench joining the host end to the converter end
`timescale 1ns/1ps
`include "sac_params.svh"
module testbench;
   import sac_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        ext_clk_mode = 1'b0;
   sac_res_t    res_sel = SAC_RES_12;
   logic        cmp_high = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wdata = 16'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic        irq;
   logic        conv_done;
   logic [11:0] vin = 12'h0;
   int          bad_count = 0;
   int          n_checks = 0;
   int          cycles = 0;

   sac_if sac_if_i ();
   sac_device sac_device_i (.clock(clock), .rst_n(rst_n), .link(sac_if_i), .ext_clk_mode(ext_clk_mode),
                            .res_sel(res_sel), .cmp_high(cmp_high), .conv_done(conv_done));
   sac_host sac_host_i (.clock(clock), .rst_n(rst_n), .link(sac_if_i), .addr(addr), .wdata(wdata),
                        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
   sac_link_checker sac_link_checker_i (.clock(clock), .rst_n(rst_n), .start(sac_if_i.start),
      .busy(sac_if_i.busy), .bit_clk(sac_if_i.bit_clk), .serial_data(sac_if_i.serial_data),
      .result(sac_if_i.result), .result_msb_n(sac_if_i.result_msb_n));

   ////////////////////////////////////////////////////////////////
   always #5 clock = ~clock;
   // Ideal comparator: true trial code is the complement of the result lines
   always @(posedge clock) cmp_high <= (vin >= ~sac_if_i.result);
   // Hang guard, well above the longest expected run
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Settle past the edge so flop updates have landed
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string what);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk_word(rdata, exp, what);
   endtask
   task automatic go_wait;
      int k;
      k = 0;
      wr_reg(`SAC_A_CTRL, 16'h1);
      while (sac_if_i.busy !== 1'b1 && k < 60) begin
         tick();
         k++;
      end
      while (sac_if_i.busy === 1'b1 && k < 1200) begin
         tick();
         k++;
      end
      repeat (8) tick();
   endtask

   ////////////////////////////////////////////////////////////////
   // One conversion, watching the wire; truncated bits must read as true zero
   task automatic convert(input sac_res_t r, input logic ext, input logic [11:0] v, input int n);
      logic [11:0] mask;
      logic [11:0] ser;
      logic        pbc;
      logic        pst;
      int          len;
      int          tail;
      int          falls;
      int          lo;
      int          per;
      int          dones;
      mask = 12'hfff << (12 - n);
      ser = 12'h0;
      pbc = 1'b0;
      len = 0;
      tail = 0;
      falls = 0;
      lo = 0;
      per = 1000;
      dones = 0;
      @(posedge clock);
      vin <= v;
      res_sel <= r;
      ext_clk_mode <= ext;
      wr_reg(`SAC_A_CTRL, {14'h0, ext, 1'b1});
      while (sac_if_i.busy !== 1'b1 && tail < 60) begin
         tick();
         tail++;
      end
      chk_bit(sac_if_i.busy, 1'b1, "busy rise");
      tail = 0;
      pst = sac_if_i.start;
      while (tail < 30 && len < 1200) begin
         tick();
         len += (sac_if_i.busy === 1'b1);
         tail += (sac_if_i.busy !== 1'b1);
         if (pst && !sac_if_i.start) falls++;
         if (!sac_if_i.start && falls > 0) lo++;
         if (sac_if_i.start && lo > 0) begin
            chk_bit(lo >= 10 && lo <= 20, 1'b1, "pulse low width");
            lo = 0;
         end
         if (pbc && !sac_if_i.bit_clk) ser = {ser[10:0], sac_if_i.serial_data};
         per++;
         dones += conv_done;
         // First rise has no predecessor, so the large seed skips it
         if (!pbc && sac_if_i.bit_clk && !ext && per < 100)
            chk_word(16'(per), 16'(n == 8 ? `SAC_BIT_CYC_8 : `SAC_BCLK_CYC), "bit period");
         if (!pbc && sac_if_i.bit_clk) per = 0;
         if (!ext && sac_if_i.busy === 1'b1) chk_bit(sac_if_i.start, 1'b0, "start held low");
         pbc = sac_if_i.bit_clk;
         pst = sac_if_i.start;
      end
      chk_bit(len <= 100 * (n == 12 ? 10 : n == 10 ? 8 : 4), 1'b1, "conversion time");
      chk_word({4'h0, sac_if_i.result}, {4'h0, ~(v & mask)}, "parallel code");
      chk_bit(sac_if_i.result_msb_n, v[11], "inverted msb");
      chk_word({4'h0, ser}, {4'h0, (~v) >> (12 - n)}, "serial code");
      if (ext) chk_word(16'(falls), 16'd12, "pacing pulses");
      chk_word(16'(dones), 16'd1, "done pulse");
      chk_bit(irq, 1'b1, "done irq");
      rd_chk(`SAC_A_RES, {3'h0, v[11], ~(v & mask)}, "result reg");
      wr_reg(`SAC_A_CLR, 16'h3);
      tick();
      tick();
      chk_bit(irq, 1'b0, "irq cleared");
   endtask
   // Second done while the first is unread, masked and then unmasked
   task automatic t_overrun;
      wr_reg(`SAC_A_EN, 16'h0);
      go_wait();
      go_wait();
      rd_chk(`SAC_A_STAT, 16'h3, "done and overrun");
      chk_bit(irq, 1'b0, "irq masked");
      wr_reg(`SAC_A_EN, 16'h3);
      tick();
      tick();
      chk_bit(irq, 1'b1, "irq unmasked");
      wr_reg(`SAC_A_CLR, 16'h3);
      rd_chk(`SAC_A_STAT, 16'h0, "status cleared");
   endtask
   // Reset in mid conversion must abandon it cleanly
   task automatic t_reset_mid;
      wr_reg(`SAC_A_CTRL, 16'h1);
      repeat (200) tick();
      rd_chk(`SAC_A_STAT, 16'h4, "live busy");
      @(posedge clock);
      rst_n <= 1'b0;
      tick();
      chk_word({3'h0, sac_if_i.result_msb_n, sac_if_i.result}, 16'h0fff, "reset result");
      chk_bit(sac_if_i.busy, 1'b0, "reset busy");
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      wr_reg(`SAC_A_EN, 16'h1);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      tick();
      chk_word({4'h0, sac_if_i.result}, 16'h0fff, "idle result");
      rd_chk(`SAC_A_EN, 16'h0, "enable reset");
      rd_chk(`SAC_A_STAT, 16'h0, "status reset");
      rd_chk(3'h6, 16'h0, "unmapped read");
      wr_reg(3'h7, 16'hffff);
      wr_reg(`SAC_A_EN, 16'h1);
      convert(SAC_RES_12, 1'b0, 12'h000, 12);
      convert(SAC_RES_12, 1'b0, 12'hfff, 12);
      convert(SAC_RES_12, 1'b0, 12'h5a3, 12);
      convert(SAC_RES_10, 1'b0, 12'h5a3, 10);
      convert(SAC_RES_8, 1'b0, 12'h5a3, 8);
      t_overrun();
      t_reset_mid();
      convert(SAC_RES_12, 1'b1, 12'h3c6, 12);
      end_of_test();
   end
endmodule
